// *** verification/nia_seq_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// stands in for the core's sequencer: one finished instruction per start
module nia_seq_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic start,
   input wire nia_pkg::nia_instr_kind_type kind,
   input wire logic [3:0] delay,
   input wire logic rest_en,
   input wire logic rest_lvl,
   output nia_pkg::nia_instr_report_type report
);
   logic done;
   logic [4:0] cnt;
   nia_pkg::nia_instr_kind_type kind_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt <= 5'h00;
         done <= 1'b0;
         kind_q <= nia_pkg::INSTR_PLAIN;
      end else begin
         done <= (cnt == 5'h01);
         if (start) begin
            // software decides the enable and level that returns restore; relayed as given
            cnt <= {1'b0, delay} + 5'h01;
            kind_q <= kind;
         end else if (cnt != 5'h00) begin
            cnt <= cnt - 5'h01;
         end
      end
   end
   assign report = {done, kind_q, rest_en, rest_lvl};
endmodule : nia_seq_model
`default_nettype wire

// *** verification/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [7:0] source_event = 8'h00, reqm = 8'h00, lvl = 8'hff, msk = 8'hff, r;
   nia_pkg::nia_instr_report_type rep;
   nia_pkg::nia_accept_type acc;
   nia_pkg::nia_instr_kind_type kind = nia_pkg::INSTR_PLAIN;
   logic en_o, isl_o, start = 0, rest_en = 0, rest_lvl = 0, en = 0, isl = 1;
   logic [3:0] dly = 4'h0;
   int bad_count = 0, comparisons = 0, seed = 26292;
   logic [7:0] ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
   logic [7:0] rv [6] = '{8'h00, 8'hff, 8'hff, 8'h02, 8'h00, 8'h00};
   assign hready = hreadyout;
   always #2 hclk = ~hclk;
   nia_acceptance nia_acceptance_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .source_event(source_event), .instr_report(rep), .accept(acc),
      .ack_enable_flag(en_o), .in_service_level_flag(isl_o));
   nia_seq_model nia_seq_model_inst (.hclk(hclk), .hresetn(hresetn), .start(start),
      .kind(kind), .delay(dly), .rest_en(rest_en), .rest_lvl(rest_lvl), .report(rep));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
         bad_count++;
      end
   endtask : chk
   function automatic logic [4:0] pick(input logic [7:0] q, input logic [7:0] l);
      for (int p = 0; p < 2; p++)
         for (int i = 0; i < 8; i++)
            if (q[i] && l[i] == p[0]) return {1'b1, p[0], i[2:0]};
      return 5'h00;
   endfunction : pick
   // bounded wait for hready; a hang ends the run as a failure
   task automatic wt();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (n >= 20) begin
         bad_count++;
         stop_test();
      end
   endtask : wt
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= nia_pkg::HTRANS_NONSEQ;
      wt();
      htrans <= 2'h0;
      hwdata <= d;
      wt();
      rd = hrdata;
      chk(32'(nia_pkg::HRESP_OKAY), 32'(hresp));
   endtask : xfer
   task automatic ev(input logic [7:0] b);
      @(posedge hclk);
      source_event <= b;
      @(posedge hclk);
      source_event <= 8'h00;
      reqm |= b;
   endtask : ev
   task automatic instr(input nia_pkg::nia_instr_kind_type k, input logic [3:0] d);
      logic [4:0] p;
      logic v, b;
      int n;
      p = pick(reqm & ~msk, lvl);
      b = (k == nia_pkg::INSTR_SOFTWARE_BREAK);
      v = (k == nia_pkg::INSTR_PLAIN) && en && p[4] && (isl || !p[3]);
      @(posedge hclk);
      start <= 1'b1;
      kind <= k;
      dly <= d;
      @(posedge hclk);
      start <= 1'b0;
      n = 0;
      do begin
         @(posedge hclk);
         #1;
         n++;
      end while (rep.done !== 1'b1 && n < 40);
      if (n >= 40) begin
         bad_count++;
         stop_test();
      end
      // the decision is registered on the edge that samples done
      @(posedge hclk);
      #1;
      if (k == nia_pkg::INSTR_SET_ENABLE) en = 1;
      if (k == nia_pkg::INSTR_CLEAR_ENABLE) en = 0;
      if (k == nia_pkg::INSTR_VECTORED_RETURN || k == nia_pkg::INSTR_BREAK_RETURN) begin
         en = rest_en;
         isl = rest_lvl;
      end
      if (b || v) en = 0;
      if (b) isl = 1;
      if (v) isl = p[3];
      if (v) reqm[p[2:0]] = 1'b0;
      chk(32'({v | b, b}), 32'({acc.valid, acc.is_break}));
      if (v) chk(32'(p[2:0]), 32'(acc.source));
      chk(32'({en, isl}), 32'({en_o, isl_o}));
      @(posedge hclk);
      #1;
      chk(32'h0, 32'(acc.valid));
   endtask : instr
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      xfer(1, 8'h10, 32'hff);
      for (int i = 0; i < 6; i++) begin
         xfer(0, ra[i], 32'h0);
         chk({24'h0, rv[i]}, rd);
      end
      xfer(1, nia_pkg::ADDR_MASK, 32'h0);
      msk = 8'h00;
      lvl = 8'h5a;
      xfer(1, nia_pkg::ADDR_LEVEL, 32'(lvl));
      xfer(0, nia_pkg::ADDR_REQUEST, 32'h0);
      chk(32'h0, rd);
      instr(nia_pkg::INSTR_SET_ENABLE, 4'h0);
      ev(8'h08);
      instr(nia_pkg::INSTR_HOLD, 4'h3);
      instr(nia_pkg::INSTR_PLAIN, 4'h0);
      ev(8'h02);
      instr(nia_pkg::INSTR_PLAIN, 4'h0);
      xfer(0, nia_pkg::ADDR_REQUEST, 32'h0);
      chk(32'h02, rd);
      ev(8'h04);
      instr(nia_pkg::INSTR_SET_ENABLE, 4'h0);
      instr(nia_pkg::INSTR_PLAIN, 4'h2);
      instr(nia_pkg::INSTR_SET_ENABLE, 4'h0);
      instr(nia_pkg::INSTR_PLAIN, 4'h0);
      ev(8'h01);
      instr(nia_pkg::INSTR_PLAIN, 4'h0);
      rest_en <= 1'b1;
      rest_lvl <= 1'b1;
      instr(nia_pkg::INSTR_VECTORED_RETURN, 4'h0);
      instr(nia_pkg::INSTR_PLAIN, 4'h0);
      instr(nia_pkg::INSTR_SOFTWARE_BREAK, 4'h0);
      ev(8'h20);
      instr(nia_pkg::INSTR_PLAIN, 4'h0);
      instr(nia_pkg::INSTR_SET_ENABLE, 4'h0);
      instr(nia_pkg::INSTR_PLAIN, 4'h0);
      instr(nia_pkg::INSTR_BREAK_RETURN, 4'h0);
      msk = 8'h80;
      xfer(1, nia_pkg::ADDR_MASK, 32'(msk));
      ev(8'h80);
      instr(nia_pkg::INSTR_PLAIN, 4'h1);
      instr(nia_pkg::INSTR_CLEAR_ENABLE, 4'h0);
      msk = 8'h00;
      xfer(1, nia_pkg::ADDR_MASK, 32'(msk));
      instr(nia_pkg::INSTR_SET_ENABLE, 4'h0);
      instr(nia_pkg::INSTR_PLAIN, 4'h0);
      // random levels, events and instruction kinds against the bench model
      for (int i = 0; i < 40; i++) begin
         r = 8'($random(seed));
         lvl = 8'($random(seed));
         xfer(1, nia_pkg::ADDR_LEVEL, 32'(lvl));
         ev(8'($random(seed)));
         rest_en <= r[6];
         rest_lvl <= r[7];
         instr(nia_pkg::INSTR_SET_ENABLE, r[6:3]);
         instr(nia_pkg::nia_instr_kind_type'(r[2:0] % 3'h7), r[5:2]);
      end
      stop_test();
   end
endmodule : tb
`default_nettype wire

// *** verilog/nia_acceptance.sv ***
// Summary of operation
// - nesting needs acknowledge enable set
// - any acceptance clears acknowledge enable
// - equal or higher level nests when enabled
// - lower level than running routine refused
// - refused requests stay pending until accepted
// - high-level routine: only level 0 nests
// - idle or low routine: both levels nest
// - level bit 0 high, 1 low
// - break always taken; break routine nests both
// - programmed levels decide nesting and order
// - hold instruction defers acceptance one instruction
// - status word, returns, enable/disable are hold
// - flag, mask, level accesses are hold
// - break not hold; enable clear blocks maskable
// - level bits never touch request flags
// - eligible: request set and mask clear
// - accepted level copied to in-service flag
// - level first, then fixed order, on ties
`timescale 1ns/1ps
`default_nettype none

module nia_acceptance (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [nia_pkg::NUM_SRC-1:0] source_event,
   input wire nia_pkg::nia_instr_report_type instr_report,
   output nia_pkg::nia_accept_type accept,
   output logic ack_enable_flag,
   output logic in_service_level_flag
);

   ////////////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic is_hold(input nia_pkg::nia_instr_kind_type kind);
      is_hold = (kind != nia_pkg::INSTR_PLAIN) && (kind != nia_pkg::INSTR_SOFTWARE_BREAK);
   endfunction : is_hold

   // lowest level value wins, then lowest index
   function automatic nia_pkg::nia_pick_type pick(input logic [nia_pkg::NUM_SRC-1:0] elig,
                                                  input logic [nia_pkg::NUM_SRC-1:0] lvl);
      nia_pkg::nia_pick_type res;
      res = '0;
      for (int i = nia_pkg::NUM_SRC - 1; i >= 0; i--) begin
         if (elig[i] && !lvl[i]) begin
            res.found = 1'b1;
            res.level = 1'b0;
            res.source = i[nia_pkg::IDX_W-1:0];
         end
      end
      if (!res.found) begin
         for (int i = nia_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (elig[i]) begin
               res.found = 1'b1;
               res.level = 1'b1;
               res.source = i[nia_pkg::IDX_W-1:0];
            end
         end
      end
      pick = res;
   endfunction : pick

   ////////////////////////////////////////////////////////////////////////////////
   // bus slave: zero wait states, always OKAY

   logic wr_pend;
   logic [7:0] wr_addr;
   logic next_wr_pend;
   logic [7:0] next_wr_addr;
   logic [31:0] next_hrdata;
   logic addr_take;

   logic [nia_pkg::NUM_SRC-1:0] request_flags;
   logic [nia_pkg::NUM_SRC-1:0] mask_flags;
   logic [nia_pkg::NUM_SRC-1:0] level_bits;

   assign hreadyout = 1'b1;
   assign hresp = nia_pkg::HRESP_OKAY;
   assign addr_take = hsel && hready && (htrans == nia_pkg::HTRANS_NONSEQ);

   always_comb begin
      // writes above the map are dropped rather than aliased onto the low byte
      next_wr_pend = addr_take && hwrite && (haddr[31:8] == '0);
      next_wr_addr = wr_addr;
      next_hrdata = hrdata;
      if (addr_take) begin
         next_wr_addr = haddr[7:0];
      end
      if (addr_take && !hwrite) begin
         next_hrdata = '0;
         if (haddr[31:8] == '0) begin
            unique case (haddr[7:0])
               nia_pkg::ADDR_REQUEST: next_hrdata[7:0] = request_flags;
               nia_pkg::ADDR_MASK: next_hrdata[7:0] = mask_flags;
               nia_pkg::ADDR_LEVEL: next_hrdata[7:0] = level_bits;
               nia_pkg::ADDR_STATUS: begin
                  next_hrdata[nia_pkg::BIT_ENABLE] = ack_enable_flag;
                  next_hrdata[nia_pkg::BIT_LEVEL] = in_service_level_flag;
               end
               nia_pkg::ADDR_ACCEPT: next_hrdata[4:0] = {accept.is_break, accept.valid,
                                                         accept.source};
               default: next_hrdata = '0;
            endcase
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
         hrdata <= 32'h0000_0000;
      end else begin
         wr_pend <= next_wr_pend;
         wr_addr <= next_wr_addr;
         hrdata <= next_hrdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // flags and acceptance decision

   logic [nia_pkg::NUM_SRC-1:0] next_request_flags;
   logic [nia_pkg::NUM_SRC-1:0] next_mask_flags;
   logic [nia_pkg::NUM_SRC-1:0] next_level_bits;
   logic next_ack_enable_flag;
   logic next_in_service_level_flag;
   nia_pkg::nia_accept_type next_accept;
   nia_pkg::nia_pick_type best;
   logic [nia_pkg::NUM_SRC-1:0] eligible;
   logic boundary;
   logic may_accept;

   assign eligible = request_flags & ~mask_flags;
   assign best = pick(eligible, level_bits);
   // a finished hold instruction blocks this boundary, so the next one is seen first
   assign boundary = instr_report.done && !is_hold(instr_report.kind);
   // level 0 is high; a high-level routine lets only level 0 in
   assign may_accept = ack_enable_flag && best.found
                       && (in_service_level_flag || !best.level);

   always_comb begin
      next_request_flags = request_flags;
      next_mask_flags = mask_flags;
      next_level_bits = level_bits;
      next_ack_enable_flag = ack_enable_flag;
      next_in_service_level_flag = in_service_level_flag;
      next_accept = '0;
      next_accept.source = accept.source;
      if (wr_pend) begin
         unique case (wr_addr)
            nia_pkg::ADDR_REQUEST: next_request_flags = hwdata[nia_pkg::NUM_SRC-1:0];
            nia_pkg::ADDR_MASK: next_mask_flags = hwdata[nia_pkg::NUM_SRC-1:0];
            nia_pkg::ADDR_LEVEL: next_level_bits = hwdata[nia_pkg::NUM_SRC-1:0];
            nia_pkg::ADDR_STATUS: begin
               next_ack_enable_flag = hwdata[nia_pkg::BIT_ENABLE];
               next_in_service_level_flag = hwdata[nia_pkg::BIT_LEVEL];
            end
            default: ;
         endcase
      end
      if (instr_report.done) begin
         unique case (instr_report.kind)
            nia_pkg::INSTR_SET_ENABLE: next_ack_enable_flag = 1'b1;
            nia_pkg::INSTR_CLEAR_ENABLE: next_ack_enable_flag = 1'b0;
            nia_pkg::INSTR_VECTORED_RETURN, nia_pkg::INSTR_BREAK_RETURN: begin
               next_ack_enable_flag = instr_report.restore_enable;
               next_in_service_level_flag = instr_report.restore_level;
            end
            nia_pkg::INSTR_SOFTWARE_BREAK: begin
               // break ignores the enable and level; maskable waits behind it
               next_accept.valid = 1'b1;
               next_accept.is_break = 1'b1;
               next_ack_enable_flag = 1'b0;
               next_in_service_level_flag = 1'b1;
            end
            default: ;
         endcase
      end
      if (boundary && instr_report.kind == nia_pkg::INSTR_PLAIN && may_accept) begin
         next_accept.valid = 1'b1;
         next_accept.source = best.source;
         next_ack_enable_flag = 1'b0;
         next_in_service_level_flag = best.level;
         next_request_flags[best.source] = 1'b0;
      end
      // a fresh event beats any clear in the same cycle
      next_request_flags = next_request_flags | source_event;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         request_flags <= nia_pkg::RST_REQUEST;
         mask_flags <= nia_pkg::RST_MASK;
         level_bits <= nia_pkg::RST_LEVEL;
         ack_enable_flag <= nia_pkg::RST_STATUS[nia_pkg::BIT_ENABLE];
         in_service_level_flag <= nia_pkg::RST_STATUS[nia_pkg::BIT_LEVEL];
         accept <= '0;
      end else begin
         request_flags <= next_request_flags;
         mask_flags <= next_mask_flags;
         level_bits <= next_level_bits;
         ack_enable_flag <= next_ack_enable_flag;
         in_service_level_flag <= next_in_service_level_flag;
         accept <= next_accept;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   logic maskable_acc;
   // decision inputs one cycle late, so they can be indexed by the source that was chosen
   logic [nia_pkg::NUM_SRC-1:0] prev_level_bits;
   logic [nia_pkg::NUM_SRC-1:0] prev_eligible;
   assign maskable_acc = accept.valid && !accept.is_break;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prev_level_bits <= nia_pkg::RST_LEVEL;
         prev_eligible <= '0;
      end else begin
         prev_level_bits <= level_bits;
         prev_eligible <= eligible;
      end
   end

   AST_ENABLE_NEEDED: assert property (
      maskable_acc |-> $past(ack_enable_flag))
      else $error("maskable request accepted while acknowledge disabled");

   AST_ENABLE_CLEARED: assert property (
      accept.valid |-> !ack_enable_flag)
      else $error("acknowledge enable still set after acceptance");

   AST_LOW_REFUSED: assert property (
      maskable_acc && !$past(in_service_level_flag) |-> !prev_level_bits[accept.source])
      else $error("low level request nested into high level routine");

   AST_LEVEL_COPIED: assert property (
      maskable_acc |-> in_service_level_flag == prev_level_bits[accept.source])
      else $error("in-service level not taken from accepted source");

   AST_HOLD_DEFERS: assert property (
      instr_report.done && is_hold(instr_report.kind) |=> !maskable_acc)
      else $error("acceptance right after hold instruction");

   AST_AT_BOUNDARY: assert property (
      accept.valid |-> $past(instr_report.done))
      else $error("acceptance without instruction boundary");

   AST_ELIGIBLE: assert property (
      maskable_acc |-> prev_eligible[accept.source])
      else $error("accepted source was not eligible");

   AST_BREAK_TAKEN: assert property (
      instr_report.done && instr_report.kind == nia_pkg::INSTR_SOFTWARE_BREAK
      |=> accept.valid && accept.is_break ##1 !accept.valid)
      else $error("software break not accepted in one cycle");

   AST_HIGH_FIRST: assert property (
      maskable_acc && prev_level_bits[accept.source]
      |-> $past((request_flags & ~mask_flags & ~level_bits) == '0))
      else $error("low level chosen while high level eligible");

   COV_NESTED_LOW: cover property (
      maskable_acc && $past(in_service_level_flag) && in_service_level_flag);
   COV_BREAK: cover property (accept.valid && accept.is_break);
   COV_DEFERRED: cover property (
      instr_report.done && instr_report.kind == nia_pkg::INSTR_SET_ENABLE ##[1:8] maskable_acc);
   COV_HOLD_THEN_ACCEPT: cover property (
      instr_report.done && is_hold(instr_report.kind) ##[1:20] maskable_acc);

   AST_HIGH_NESTS: assert property (
      instr_report.done && instr_report.kind == nia_pkg::INSTR_PLAIN && ack_enable_flag
      && (eligible & ~level_bits) != '0 |=> maskable_acc && !in_service_level_flag)
      else $error("eligible high level request not accepted");

   AST_EVENT_SETS: assert property (
      source_event != '0 |=> (request_flags & $past(source_event)) == $past(source_event))
      else $error("request event did not set its flag");

   AST_PENDING_KEPT: assert property (
      !maskable_acc && !$past(wr_pend)
      |-> (request_flags & $past(request_flags)) == $past(request_flags))
      else $error("pending request lost without acceptance");

endmodule : nia_acceptance

`default_nettype wire

// *** verilog/nia_pkg.sv ***
package nia_pkg;

   localparam int NUM_SRC = 8;
   localparam int IDX_W = 3;

   // register byte offsets on the bus
   localparam logic [7:0] ADDR_REQUEST = 8'h00;
   localparam logic [7:0] ADDR_MASK = 8'h04;
   localparam logic [7:0] ADDR_LEVEL = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0c;
   localparam logic [7:0] ADDR_ACCEPT = 8'h10;

   // reset values
   localparam logic [7:0] RST_REQUEST = 8'h00;
   localparam logic [7:0] RST_MASK = 8'hff;
   localparam logic [7:0] RST_LEVEL = 8'hff;
   localparam logic [7:0] RST_STATUS = 8'h02;

   // fields of the processor status word
   localparam int BIT_ENABLE = 7;
   localparam int BIT_LEVEL = 1;
   // fields of the accept status register
   localparam int BIT_ACC_BREAK = 4;
   localparam int BIT_ACC_VALID = 3;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'h0;

   typedef enum logic [2:0] {
      INSTR_PLAIN,
      INSTR_HOLD,
      INSTR_SET_ENABLE,
      INSTR_CLEAR_ENABLE,
      INSTR_VECTORED_RETURN,
      INSTR_BREAK_RETURN,
      INSTR_SOFTWARE_BREAK
   } nia_instr_kind_type;

   // one report per finished instruction from the sequencer
   typedef struct packed {
      logic done;
      nia_instr_kind_type kind;
      logic restore_enable;
      logic restore_level;
   } nia_instr_report_type;

   typedef struct packed {
      logic valid;
      logic is_break;
      logic [IDX_W-1:0] source;
   } nia_accept_type;

   typedef struct packed {
      logic found;
      logic level;
      logic [IDX_W-1:0] source;
   } nia_pick_type;

endpackage : nia_pkg
